// [rtl/isc_pkg.sv]
// Package: constants and carriers for the interrupt and standby controller
`default_nettype none
package isc_pkg;
    localparam int ISC_NFAC = 19;
    localparam int ISC_NSYS = 8;
    localparam int ISC_AW   = 5;
    localparam int ISC_NEV  = 3;
    // Register byte offsets
    localparam logic [4:0] ISC_OFF_FLAG = 5'h00;
    localparam logic [4:0] ISC_OFF_ENA  = 5'h04;
    localparam logic [4:0] ISC_OFF_PRIO = 5'h08;
    localparam logic [4:0] ISC_OFF_STAT = 5'h0c;
    localparam logic [4:0] ISC_OFF_IMSK = 5'h10;
    localparam logic [4:0] ISC_OFF_STBY = 5'h14;
    // Values after reset
    localparam logic [18:0] ISC_RST_FLAG = 19'h00000;
    localparam logic [18:0] ISC_RST_ENA  = 19'h00000;
    localparam logic [15:0] ISC_RST_PRIO = 16'h0000;
    localparam logic [2:0]  ISC_RST_EV   = 3'h0;
    // Release locations of the watchdog request hold
    localparam logic [23:0] ISC_ADR_REL_LO = 24'h00ff00;
    localparam logic [23:0] ISC_ADR_REL_HI = 24'h00ff01;
    // Status event bit positions
    localparam int ISC_EV_TAKE  = 0;
    localparam int ISC_EV_HWAKE = 1;
    localparam int ISC_EV_SWAKE = 2;
    localparam logic [2:0] ISC_LVL_NMI  = 3'h4;
    localparam logic [1:0] ISC_MSK_NMI  = 2'h3;
    localparam logic [4:0] ISC_VEC_NMI  = 5'h1f;
    localparam logic [1:0] ISC_RESP_OK  = 2'h0;
    localparam logic [1:0] ISC_RESP_ERR = 2'h2;
    // Systems holding input-port factors, the only ones that end sleep
    localparam logic [7:0] ISC_WAKE_SYS = 8'h03;
    // System of each factor; factor index is the fixed default order
    localparam logic [2:0] ISC_SYS_OF [ISC_NFAC] = '{
        3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h4,
        3'h5, 3'h5, 3'h5, 3'h6, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7};
    typedef enum logic [1:0] {ISC_RUN, ISC_HALT, ISC_SLEEP} isc_mode_t;
    typedef struct packed {
        logic [1:0]  mask;
        logic        first_fetch;
        logic        halt_exec;
        logic        sleep_exec;
        logic        io_wr;
        logic [23:0] io_addr;
    } isc_cpu_t;
    typedef struct packed {
        logic       take;
        logic [2:0] level;
        logic [4:0] vec;
        logic [1:0] mask;
    } isc_take_t;
endpackage
`default_nettype wire

// [rtl/isc_ctrl.sv]
// Interrupt request, priority and standby control with AXI4-Lite registers
// Notes on behaviour
// - One watchdog non-maskable line plus nineteen maskable factors in eight systems.
// - Watchdog request ignores the CPU mask and beats any maskable request.
// - Watchdog request withheld after reset until both release locations written.
// - Factors: four, one, two, two, one, three, one and five per system.
// - Each factor owns a pending flag and an enable bit.
// - One priority field per system, shared by all its factors.
// - A source event sets its flag whatever the enable bit says.
// - Enable one lets the factor reach the CPU, zero blocks it.
// - Accept needs flag, enable and system level above the CPU mask.
// - Requests are sampled at each first opcode fetch and then taken.
// - Halt stops the CPU while peripherals and clocks keep running.
// - Halt ends on reset or any interrupt request.
// - Sleep stops the CPU and both oscillators.
// - Sleep ends only on reset, watchdog request or input-port interrupt.
// - Writing one clears a flag; all flags zero after reset.
// - Two-bit level 0 to 3, 3 highest, 0 never; reset to 0.
// - Equal levels resolve by the fixed default factor order.
// - Accepting raises the mask to the taken level; watchdog sets level 3.
`default_nettype none
module isc_ctrl
    import isc_pkg::*;
(
    input  wire logic                sys_clk,
    input  wire logic                sys_rst,
    input  wire logic [ISC_AW-1:0]   s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [ISC_AW-1:0]   s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    input  wire logic [ISC_NFAC-1:0] src_event,
    input  wire logic                wdt_nmi,
    input  wire isc_cpu_t            cpu,
    output isc_take_t                cpu_take,
    output logic                     cpu_stop,
    output logic                     low_speed_oscillator,
    output logic                     high_speed_oscillator,
    output logic                     irq
);
    logic [18:0]        flag_q, flag_d, ena_q, ena_d;
    logic [15:0]        prio_q, prio_d;
    logic [2:0]         stat_q, stat_d, imsk_q, imsk_d, ev;
    logic               nmi_pend_q, nmi_pend_d, hold_q, hold_d;
    logic               seen_lo_q, seen_lo_d, seen_hi_q, seen_hi_d;
    isc_mode_t          mode_q, mode_d;
    isc_take_t          take_q, take_d;
    logic [ISC_AW-1:0]  awa_q, awa_d;
    logic [31:0]        wd_q, wd_d, rd_q, rd_d;
    logic [3:0]         ws_q, ws_d;
    logic               awh_q, awh_d, wh_q, wh_d, bv_q, bv_d, rv_q, rv_d;
    logic [1:0]         br_q, br_d, rr_q, rr_d;
    logic [31:0]        wm;
    logic               wr_go, rd_go;
    logic [1:0]         lvl, best_lvl;
    logic [4:0]         best_vec;
    logic               nmi_ok, hw_ok, any_req, port_req;

    assign s_axi_awready = !awh_q && !bv_q;
    assign s_axi_wready  = !wh_q && !bv_q;
    assign s_axi_arready = !rv_q;
    assign s_axi_bvalid  = bv_q;
    assign s_axi_bresp   = br_q;
    assign s_axi_rvalid  = rv_q;
    assign s_axi_rdata   = rd_q;
    assign s_axi_rresp   = rr_q;
    assign wr_go = awh_q && wh_q && !bv_q;
    assign rd_go = s_axi_arvalid && !rv_q;
    assign wm    = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};

    // Priority resolve over the factors
    always_comb begin
        lvl      = 2'h0;
        best_lvl = 2'h0;
        best_vec = 5'h00;
        port_req = 1'b0;
        for (int i = 0; i < ISC_NFAC; i++) begin
            lvl = (flag_q[i] && ena_q[i]) ? prio_q[2*ISC_SYS_OF[i] +: 2] : 2'h0;
            if (lvl > best_lvl) begin
                best_lvl = lvl;
                best_vec = 5'(i);
            end
            if (lvl != 2'h0 && ISC_WAKE_SYS[ISC_SYS_OF[i]]) begin
                port_req = 1'b1;
            end
        end
    end

    assign nmi_ok  = nmi_pend_q && !hold_q;
    assign hw_ok   = best_lvl > cpu.mask;
    assign any_req = nmi_ok || (best_lvl != 2'h0);

    // Acceptance and standby
    always_comb begin
        take_d     = '0;
        mode_d     = mode_q;
        ev         = '0;
        nmi_pend_d = nmi_pend_q;
        if (cpu.first_fetch && mode_q == ISC_RUN) begin
            if (nmi_ok) begin
                take_d     = '{1'b1, ISC_LVL_NMI, ISC_VEC_NMI, ISC_MSK_NMI};
                nmi_pend_d = 1'b0;
            end else if (hw_ok) begin
                take_d = '{1'b1, {1'b0, best_lvl}, best_vec, best_lvl};
            end
        end
        ev[ISC_EV_TAKE] = take_d.take;
        if (wdt_nmi) begin
            nmi_pend_d = 1'b1;
        end
        unique case (mode_q)
            ISC_RUN: begin
                if (cpu.sleep_exec) begin
                    mode_d = ISC_SLEEP;
                end else if (cpu.halt_exec) begin
                    mode_d = ISC_HALT;
                end
            end
            ISC_HALT: begin
                if (any_req) begin
                    mode_d = ISC_RUN;
                    ev[ISC_EV_HWAKE] = 1'b1;
                end
            end
            ISC_SLEEP: begin
                if (nmi_ok || port_req) begin
                    mode_d = ISC_RUN;
                    ev[ISC_EV_SWAKE] = 1'b1;
                end
            end
        endcase
    end

    assign cpu_take = take_q;
    assign cpu_stop = mode_q != ISC_RUN;
    assign low_speed_oscillator  = mode_q != ISC_SLEEP;
    assign high_speed_oscillator = mode_q != ISC_SLEEP;
    assign irq = |(stat_q & imsk_q);

    // Register file and bus handshake
    always_comb begin
        flag_d = flag_q;
        ena_d  = ena_q;
        prio_d = prio_q;
        stat_d = stat_q;
        imsk_d = imsk_q;
        awh_d  = awh_q;
        awa_d  = awa_q;
        wh_d   = wh_q;
        wd_d   = wd_q;
        ws_d   = ws_q;
        bv_d   = bv_q;
        br_d   = br_q;
        rv_d   = rv_q;
        rd_d   = rd_q;
        rr_d   = rr_q;
        if (s_axi_awvalid && s_axi_awready) begin
            awh_d = 1'b1;
            awa_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wh_d = 1'b1;
            wd_d = s_axi_wdata;
            ws_d = s_axi_wstrb;
        end
        if (wr_go) begin
            awh_d = 1'b0;
            wh_d  = 1'b0;
            bv_d  = 1'b1;
            br_d  = ISC_RESP_OK;
            unique case ({awa_q[4:2], 2'b00})
                ISC_OFF_FLAG: flag_d = flag_q & ~(wd_q[18:0] & wm[18:0]);
                ISC_OFF_ENA:  ena_d  = (ena_q & ~wm[18:0]) | (wd_q[18:0] & wm[18:0]);
                ISC_OFF_PRIO: prio_d = (prio_q & ~wm[15:0]) | (wd_q[15:0] & wm[15:0]);
                ISC_OFF_STAT: stat_d = stat_q & ~(wd_q[2:0] & wm[2:0]);
                ISC_OFF_IMSK: imsk_d = (imsk_q & ~wm[2:0]) | (wd_q[2:0] & wm[2:0]);
                ISC_OFF_STBY: ;
                default:      br_d = ISC_RESP_ERR;
            endcase
        end
        if (bv_q && s_axi_bready) begin
            bv_d = 1'b0;
        end
        if (rv_q && s_axi_rready) begin
            rv_d = 1'b0;
        end
        if (rd_go) begin
            rv_d = 1'b1;
            rr_d = ISC_RESP_OK;
            unique case ({s_axi_araddr[4:2], 2'b00})
                ISC_OFF_FLAG: rd_d = {13'h0, flag_q};
                ISC_OFF_ENA:  rd_d = {13'h0, ena_q};
                ISC_OFF_PRIO: rd_d = {16'h0, prio_q};
                ISC_OFF_STAT: rd_d = {29'h0, stat_q};
                ISC_OFF_IMSK: rd_d = {29'h0, imsk_q};
                ISC_OFF_STBY: rd_d = {27'h0, nmi_pend_q, hold_q, 1'b0, mode_q};
                default: begin
                    rd_d = 32'h0;
                    rr_d = ISC_RESP_ERR;
                end
            endcase
        end
        // event sets flag, set beats clear
        flag_d = flag_d | src_event;
        stat_d = stat_d | ev;
    end

    always_comb begin
        seen_lo_d = seen_lo_q || (cpu.io_wr && cpu.io_addr == ISC_ADR_REL_LO);
        seen_hi_d = seen_hi_q || (cpu.io_wr && cpu.io_addr == ISC_ADR_REL_HI);
        hold_d    = hold_q && !(seen_lo_q && seen_hi_q);
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            flag_q     <= ISC_RST_FLAG;
            ena_q      <= ISC_RST_ENA;
            prio_q     <= ISC_RST_PRIO;
            stat_q     <= ISC_RST_EV;
            imsk_q     <= ISC_RST_EV;
            nmi_pend_q <= 1'b0;
            hold_q     <= 1'b1;
            seen_lo_q  <= 1'b0;
            seen_hi_q  <= 1'b0;
            mode_q     <= ISC_RUN;
            take_q     <= '0;
            awh_q      <= 1'b0;
            awa_q      <= '0;
            wh_q       <= 1'b0;
            wd_q       <= 32'h0;
            ws_q       <= 4'h0;
            bv_q       <= 1'b0;
            br_q       <= ISC_RESP_OK;
            rv_q       <= 1'b0;
            rd_q       <= 32'h0;
            rr_q       <= ISC_RESP_OK;
        end else begin
            flag_q     <= flag_d;
            ena_q      <= ena_d;
            prio_q     <= prio_d;
            stat_q     <= stat_d;
            imsk_q     <= imsk_d;
            nmi_pend_q <= nmi_pend_d;
            hold_q     <= hold_d;
            seen_lo_q  <= seen_lo_d;
            seen_hi_q  <= seen_hi_d;
            mode_q     <= mode_d;
            take_q     <= take_d;
            awh_q      <= awh_d;
            awa_q      <= awa_d;
            wh_q       <= wh_d;
            wd_q       <= wd_d;
            ws_q       <= ws_d;
            bv_q       <= bv_d;
            br_q       <= br_d;
            rv_q       <= rv_d;
            rd_q       <= rd_d;
            rr_q       <= rr_d;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    chk_nmi_held: assert property (hold_q |=> !(take_q.take && take_q.vec == ISC_VEC_NMI))
        else $error("watchdog request taken while held");
    chk_nmi_wins: assert property (cpu.first_fetch && mode_q == ISC_RUN && nmi_ok
        |=> take_q.take && take_q.level == ISC_LVL_NMI)
        else $error("watchdog request lost to maskable one");
    chk_flag_sets: assert property (|src_event |=> (flag_q & $past(src_event))
        == $past(src_event))
        else $error("event did not set its flag");
    chk_take_above: assert property (take_q.take && take_q.vec != ISC_VEC_NMI
        |-> take_q.level[1:0] > $past(cpu.mask))
        else $error("request taken at or below mask");
    chk_mask_raise: assert property (take_q.take |-> take_q.mask ==
        ((take_q.vec == ISC_VEC_NMI) ? ISC_MSK_NMI : take_q.level[1:0]))
        else $error("new mask does not match taken level");
    chk_halt_clocks: assert property (mode_q == ISC_HALT |-> cpu_stop
        && low_speed_oscillator && high_speed_oscillator)
        else $error("halt stopped a clock");
    chk_sleep_osc: assert property (mode_q == ISC_SLEEP |-> cpu_stop
        && !low_speed_oscillator && !high_speed_oscillator)
        else $error("sleep left an oscillator running");
    chk_sleep_exit: assert property ($past(mode_q) == ISC_SLEEP && mode_q == ISC_RUN
        |-> $past(nmi_ok || port_req))
        else $error("sleep ended without a wake source");
    chk_halt_exit: assert property (mode_q == ISC_HALT && any_req |=> mode_q == ISC_RUN)
        else $error("halt ignored a request");
    chk_hold_stays: assert property (!hold_q |=> !hold_q)
        else $error("watchdog hold came back");

    cov_hw_take: cover property (take_q.take && take_q.vec != ISC_VEC_NMI);
    cov_nmi_take: cover property (take_q.take && take_q.vec == ISC_VEC_NMI);
    cov_halt_wake: cover property (mode_q == ISC_HALT ##1 mode_q == ISC_RUN);
    cov_sleep_wake: cover property (mode_q == ISC_SLEEP ##1 mode_q == ISC_RUN);
endmodule // isc_ctrl
`default_nettype wire

// [verif/isc_cpu_model.sv]
// CPU core model: mask bits, opcode fetch, standby and io write strobes
`default_nettype none
module isc_cpu_model
    import isc_pkg::*;
(
    input  wire logic      sys_clk,
    output var isc_cpu_t   cpu,
    input  wire isc_take_t cpu_take
);
    timeunit 1ns;
    timeprecision 1ps;

    initial cpu = '0;

    task automatic set_mask(input logic [1:0] m);
        @(posedge sys_clk);
        cpu.mask <= m;
    endtask

    // fetch samples requests, mask follows the accepted level
    task automatic fetch(output isc_take_t t);
        @(posedge sys_clk);
        cpu.first_fetch <= 1'h1;
        @(posedge sys_clk);
        cpu.first_fetch <= 1'h0;
        #1;
        t = cpu_take;
        if (t.take === 1'h1) cpu.mask <= t.mask;
    endtask

    // one-cycle strobes; address scrambled once released
    task automatic pulse(input logic h, input logic s, input logic w, input logic [23:0] a);
        @(posedge sys_clk);
        cpu.halt_exec <= h;
        cpu.sleep_exec <= s;
        cpu.io_wr <= w;
        cpu.io_addr <= a;
        @(posedge sys_clk);
        cpu.halt_exec <= 1'h0;
        cpu.sleep_exec <= 1'h0;
        cpu.io_wr <= 1'h0;
        cpu.io_addr <= ~a;
    endtask
endmodule // isc_cpu_model
`default_nettype wire

// [verif/isc_ctrl_tb_top.sv]
// Self-checking testbench for the interrupt and standby controller
`default_nettype none
module isc_ctrl_tb_top
    import isc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                sys_clk = 1'h0;
    logic                sys_rst = 1'h1;
    logic [ISC_AW-1:0]   s_axi_awaddr = '0, s_axi_araddr = '0;
    logic                s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic                s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [31:0]         s_axi_wdata = '0, s_axi_rdata, rd;
    logic [3:0]          s_axi_wstrb = 4'hf;
    logic                s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]          s_axi_bresp, s_axi_rresp, rs;
    logic [ISC_NFAC-1:0] src_event = '0;
    logic                wdt_nmi = 1'h0;
    isc_cpu_t            cpu;
    isc_take_t           cpu_take, t;
    logic                cpu_stop, low_speed_oscillator, high_speed_oscillator, irq;
    int                  n_errors = 0, checks = 0, cyc = 0;

    isc_ctrl isc_ctrl_i (
        .sys_clk               (sys_clk),
        .sys_rst               (sys_rst),
        .s_axi_awaddr          (s_axi_awaddr),
        .s_axi_awvalid         (s_axi_awvalid),
        .s_axi_awready         (s_axi_awready),
        .s_axi_wdata           (s_axi_wdata),
        .s_axi_wstrb           (s_axi_wstrb),
        .s_axi_wvalid          (s_axi_wvalid),
        .s_axi_wready          (s_axi_wready),
        .s_axi_bresp           (s_axi_bresp),
        .s_axi_bvalid          (s_axi_bvalid),
        .s_axi_bready          (s_axi_bready),
        .s_axi_araddr          (s_axi_araddr),
        .s_axi_arvalid         (s_axi_arvalid),
        .s_axi_arready         (s_axi_arready),
        .s_axi_rdata           (s_axi_rdata),
        .s_axi_rresp           (s_axi_rresp),
        .s_axi_rvalid          (s_axi_rvalid),
        .s_axi_rready          (s_axi_rready),
        .src_event             (src_event),
        .wdt_nmi               (wdt_nmi),
        .cpu                   (cpu),
        .cpu_take              (cpu_take),
        .cpu_stop              (cpu_stop),
        .low_speed_oscillator  (low_speed_oscillator),
        .high_speed_oscillator (high_speed_oscillator),
        .irq                   (irq)
    );
    isc_cpu_model isc_cpu_model_i (.sys_clk(sys_clk), .cpu(cpu), .cpu_take(cpu_take));

    initial forever #5 sys_clk = ~sys_clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Channels are judged at the rising edge on the values they carried into it;
    // only the bench timeout ends a wait that never gets its answer
    task automatic wr(input logic [ISC_AW-1:0] a, input logic [31:0] d);
        logic b = 1'h0;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!b) begin
            @(posedge sys_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
            b = s_axi_bvalid;
            rs = s_axi_bresp;
        end
        s_axi_bready <= 1'h0;
    endtask

    task automatic rdr(input logic [ISC_AW-1:0] a);
        logic r = 1'h0;
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        while (!r) begin
            @(posedge sys_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
            r = s_axi_rvalid;
            rd = s_axi_rdata;
            rs = s_axi_rresp;
        end
        s_axi_rready <= 1'h0;
    endtask

    task automatic rchk(input logic [ISC_AW-1:0] a, input logic [31:0] e);
        rdr(a);
        chk(rd, e);
    endtask

    task automatic ev(input logic [ISC_NFAC-1:0] m);
        @(posedge sys_clk);
        src_event <= m;
        @(posedge sys_clk);
        src_event <= '0;
    endtask

    task automatic nmi();
        @(posedge sys_clk);
        wdt_nmi <= 1'h1;
        @(posedge sys_clk);
        wdt_nmi <= 1'h0;
    endtask

    task automatic fchk(input logic [1:0] m, input logic [10:0] e);
        isc_cpu_model_i.set_mask(m);
        isc_cpu_model_i.fetch(t);
        chk(32'(t), 32'(e));
    endtask

    task automatic t_reset();
        rchk(ISC_OFF_FLAG, 32'h0);
        rchk(ISC_OFF_ENA, 32'h0);
        rchk(ISC_OFF_PRIO, 32'h0);
        rchk(ISC_OFF_STBY, 32'h8);
        rdr(5'h18);
        chk(32'(rs), 32'(ISC_RESP_ERR));
        wr(5'h1c, 32'hffffffff);
        chk(32'(rs), 32'(ISC_RESP_ERR));
        chk(32'({cpu_stop, low_speed_oscillator, high_speed_oscillator, irq}), 32'h6);
    endtask

    task automatic t_flags();
        ev(19'h00020);
        rchk(ISC_OFF_FLAG, 32'h20);
        ev(19'h7ffff);
        rchk(ISC_OFF_FLAG, 32'h7ffff);
        wr(ISC_OFF_FLAG, 32'h20);
        chk(32'(rs), 32'(ISC_RESP_OK));
        rchk(ISC_OFF_FLAG, 32'h7ffdf);
        wr(ISC_OFF_FLAG, 32'h7ffff);
        rchk(ISC_OFF_FLAG, 32'h0);
    endtask

    task automatic t_accept();
        ev(19'h00020);
        fchk(2'h0, 11'h0);
        wr(ISC_OFF_ENA, 32'h30);
        wr(ISC_OFF_PRIO, 32'h28);
        fchk(2'h2, 11'h0);
        fchk(2'h1, {1'h1, 3'h2, 5'h05, 2'h2});
        ev(19'h00010);
        fchk(2'h1, {1'h1, 3'h2, 5'h04, 2'h2});
        #1 chk(32'(irq), 32'h0);
        wr(ISC_OFF_IMSK, 32'h1);
        #1 chk(32'(irq), 32'h1);
        wr(ISC_OFF_STAT, 32'h1);
        #1 chk(32'(irq), 32'h0);
        wr(ISC_OFF_FLAG, 32'h7ffff);
    endtask

    task automatic t_nmi();
        wr(ISC_OFF_PRIO, 32'h30);
        wr(ISC_OFF_ENA, 32'h20);
        ev(19'h00020);
        nmi();
        fchk(2'h0, {1'h1, 3'h3, 5'h05, 2'h3});
        isc_cpu_model_i.pulse(1'h0, 1'h0, 1'h1, ISC_ADR_REL_LO);
        repeat (2) @(posedge sys_clk);
        fchk(2'h3, 11'h0);
        isc_cpu_model_i.pulse(1'h0, 1'h0, 1'h1, ISC_ADR_REL_HI);
        repeat (2) @(posedge sys_clk);
        fchk(2'h0, {1'h1, ISC_LVL_NMI, ISC_VEC_NMI, ISC_MSK_NMI});
        isc_cpu_model_i.pulse(1'h0, 1'h0, 1'h1, ISC_ADR_REL_LO);
        nmi();
        fchk(2'h3, {1'h1, ISC_LVL_NMI, ISC_VEC_NMI, ISC_MSK_NMI});
        wr(ISC_OFF_FLAG, 32'h7ffff);
    endtask

    task automatic t_standby();
        wr(ISC_OFF_PRIO, 32'h4001);
        wr(ISC_OFF_ENA, 32'h4001);
        isc_cpu_model_i.pulse(1'h1, 1'h0, 1'h0, 24'h0);
        #1 chk(32'({cpu_stop, low_speed_oscillator, high_speed_oscillator}), 32'h7);
        ev(19'h04000);
        repeat (3) @(posedge sys_clk);
        #1 chk(32'(cpu_stop), 32'h0);
        wr(ISC_OFF_FLAG, 32'h7ffff);
        isc_cpu_model_i.pulse(1'h0, 1'h1, 1'h0, 24'h0);
        #1 chk(32'({cpu_stop, low_speed_oscillator, high_speed_oscillator}), 32'h4);
        rchk(ISC_OFF_STBY, 32'h2);
        ev(19'h04000);
        repeat (3) @(posedge sys_clk);
        #1 chk(32'({cpu_stop, low_speed_oscillator, high_speed_oscillator}), 32'h4);
        ev(19'h00001);
        repeat (3) @(posedge sys_clk);
        #1 chk(32'({cpu_stop, low_speed_oscillator, high_speed_oscillator}), 32'h3);
        rchk(ISC_OFF_STAT, 32'h7);
    endtask

    // Mid-run reset brings the watchdog hold and cleared registers back
    task automatic t_rereset();
        @(posedge sys_clk);
        sys_rst <= 1'h1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'h0;
        rchk(ISC_OFF_STBY, 32'h8);
        rchk(ISC_OFF_FLAG, 32'h0);
        rchk(ISC_OFF_PRIO, 32'h0);
    endtask

    task automatic report_and_stop();
        if (n_errors == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Whole run needs about two hundred cycles; the ceiling of 20000 leaves ample margin
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            report_and_stop();
        end
    end

    initial begin
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'h0;
        t_reset();
        t_flags();
        t_accept();
        t_nmi();
        t_standby();
        t_rereset();
        report_and_stop();
    end
endmodule // isc_ctrl_tb_top
`default_nettype wire
